// file: tb/core_feature_word_asserts.sv
// Purpose: Port assertions for the feature word.
// Assumes: Bound onto the top module.
// Notes: Fixed fields are checked every cycle.
`timescale 1ns/1ps
`default_nettype none
module core_feature_word_asserts
    import core_cfg_pkg::*;
#(parameter int ADDR_W = 32)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Watched ports
    input wire cp0_req_t cp0_req,
    input wire logic [31:0] cp0_rdata,
    input wire logic cp0_rvalid,
    input wire logic cp0_hit,
    input wire logic lookup_valid,
    input wire logic [ADDR_W-1:0] lookup_addr,
    input wire access_attr_t lookup_attr,
    input wire feature_word_t feature
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic hit_wr;
    logic hit_rd;
    logic [2:0] ep;
    assign hit_wr = cp0_req.wr && cp0_req.regnum == 5'h10 && cp0_req.sel == 3'h0;
    assign hit_rd = cp0_req.rd && cp0_req.regnum == 5'h10 && cp0_req.sel == 3'h0;
    // Unused codes fold onto uncached
    assign ep = (cp0_req.wdata[2:0] == 3'h0 || cp0_req.wdata[2:0] == 3'h3) ? cp0_req.wdata[2:0] : 3'h2;
    property p_msb; feature[31] == 1'b1; endproperty
    a_msb: assert property (p_msb) else $error("msb");
    property p_unimpl; feature[30:25] == 6'h00 && feature[19] == 1'b0 && feature[6:3] == 4'h0; endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimpl");
    property p_absent; feature[24:22] == 3'h0; endproperty
    a_absent: assert property (p_absent) else $error("absent");
    property p_opts; feature[21:15] == 7'h48; endproperty
    a_opts: assert property (p_opts) else $error("opts");
    property p_isa; feature[14:7] == 8'h09; endproperty
    a_isa: assert property (p_isa) else $error("isa");
    property p_write; hit_wr |=> feature[2:0] == $past(ep); endproperty
    a_write: assert property (p_write) else $error("write");
    property p_hold; !hit_wr |=> $stable(feature[2:0]); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_read; hit_rd |=> cp0_rvalid && cp0_hit && cp0_rdata == $past(feature); endproperty
    a_read: assert property (p_read) else $error("read");
    property p_win;
        lookup_valid && lookup_addr[31:29] == 3'h4 |=> lookup_attr.cacheable == ($past(feature[2:0]) != 3'h2)
            && lookup_attr.write_back == ($past(feature[2:0]) == 3'h3);
    endproperty
    a_win: assert property (p_win) else $error("window");
endmodule
bind core_feature_word core_feature_word_asserts #(.ADDR_W(ADDR_W)) chk_u (.mclk(mclk), .arst_n(arst_n),
    .cp0_req(cp0_req), .cp0_rdata(cp0_rdata), .cp0_rvalid(cp0_rvalid), .cp0_hit(cp0_hit),
    .lookup_valid(lookup_valid), .lookup_addr(lookup_addr), .lookup_attr(lookup_attr), .feature(feature));
`default_nettype wire

// file: tb/core_feature_word_bench.sv
// Purpose: Self-checking bench for the feature word.
// Assumes: One-cycle answers on both ports.
// Notes: Inputs move on the falling edge only.
`timescale 1ns/1ps
`default_nettype none
module core_feature_word_bench
    import core_cfg_pkg::*;
;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    cp0_req_t cp0_req = '0;
    logic [31:0] cp0_rdata;
    logic cp0_rvalid;
    logic cp0_hit;
    logic lookup_valid = 1'b0;
    logic [31:0] lookup_addr = 32'h0;
    logic [3:0] lookup_byte_en = 4'hF;
    logic mmu_enabled = 1'b0;
    access_attr_t lookup_attr;
    logic lookup_attr_valid;
    feature_word_t feature;
    logic [2:0] ep;
    int fails = 0;
    int cmp_count = 0;
    core_feature_word #(.ADDR_W(32)) dut_u (.mclk(mclk), .arst_n(arst_n), .cp0_req(cp0_req),
        .cp0_rdata(cp0_rdata), .cp0_rvalid(cp0_rvalid), .cp0_hit(cp0_hit), .lookup_valid(lookup_valid),
        .lookup_addr(lookup_addr), .lookup_byte_en(lookup_byte_en), .mmu_enabled(mmu_enabled),
        .lookup_attr(lookup_attr), .lookup_attr_valid(lookup_attr_valid), .feature(feature));
    initial begin
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [4:0] rn, input logic [31:0] exp, input logic hit);
        @(negedge mclk);
        cp0_req.rd = 1'b1;
        cp0_req.regnum = rn;
        @(negedge mclk);
        cp0_req.rd = 1'b0;
        chk(cp0_rdata, exp);
        chk(32'({cp0_rvalid, cp0_hit}), 32'({1'b1, hit}));
    endtask
    task automatic wr_reg(input logic [4:0] rn, input logic [31:0] d);
        @(negedge mclk);
        cp0_req.wr = 1'b1;
        cp0_req.regnum = rn;
        cp0_req.wdata = d;
        @(negedge mclk);
        cp0_req.wr = 1'b0;
    endtask
    task automatic lk_chk(input logic [31:0] a, input access_attr_t exp);
        @(negedge mclk);
        lookup_valid = 1'b1;
        lookup_addr = a;
        @(negedge mclk);
        lookup_valid = 1'b0;
        chk(32'({lookup_attr_valid, lookup_attr}), 32'({1'b1, exp}));
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge mclk);
        arst_n = 1'b1;
        rd_chk(5'h10, 32'h8024_0482, 1'b1);
        rd_chk(5'h11, 32'h0, 1'b0);
        for (int c = 0; c < 8; c++) begin
            ep = (c == 0 || c == 3) ? 3'(c) : 3'h2;
            wr_reg(5'h10, 32'hFFFF_FFF8 | 32'(c));
            chk(32'(feature), 32'h8024_0480 | 32'(ep));
            rd_chk(5'h10, 32'h8024_0480 | 32'(ep), 1'b1);
            lk_chk(32'h8000_0000, '{WIN_CACHED_UNMAPPED, ep != 3'h2, ep == 3'h3, ep == 3'h3, 1'b1, 1'b0});
        end
        wr_reg(5'h11, 32'h3);
        rd_chk(5'h10, 32'h8024_0482, 1'b1);
        // Read and write on one edge: read sees the old word
        @(negedge mclk);
        cp0_req = '{1'b1, 1'b1, 5'h10, 3'h0, 32'h3};
        @(negedge mclk);
        cp0_req = '0;
        chk(cp0_rdata, 32'h8024_0482);
        rd_chk(5'h10, 32'h8024_0483, 1'b1);
        lk_chk(32'h0000_0000, '{WIN_OTHER, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0});
        lk_chk(32'hC000_0000, '{WIN_MAPPED_HIGH, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1});
        mmu_enabled = 1'b1;
        lk_chk(32'hC000_0000, '{WIN_MAPPED_HIGH, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0});
        lookup_byte_en = 4'h5;
        lk_chk(32'hA000_0000, '{WIN_UNCACHED_UNMAPPED, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1});
        arst_n = 1'b0;
        repeat (2) @(negedge mclk);
        arst_n = 1'b1;
        rd_chk(5'h10, 32'h8024_0482, 1'b1);
        give_verdict();
    end
endmodule
`default_nettype wire

// file: verilog/core_cfg_pkg.sv
// Purpose: Shared constants and types for the core feature word block.
// Assumes: Accessed over the coprocessor-0 register port of the core.
// Notes: All fixed field values of the feature word live here.
package core_cfg_pkg;

    // Coprocessor-0 location of the feature word
    localparam logic [4:0] CP0_REG_FEATURE = 5'h10;
    localparam logic [2:0] CP0_SEL_FEATURE = 3'h0;

    // Field positions
    localparam int POS_SECOND_WORD = 31;
    localparam int POS_SCRATCH_I = 24;
    localparam int POS_SCRATCH_D = 23;
    localparam int POS_CUSTOM = 22;
    localparam int POS_SIMPLE_BE = 21;
    localparam int POS_MULDIV_KIND = 20;
    localparam int POS_MERGE_LO = 17;
    localparam int POS_BURST = 16;
    localparam int POS_ENDIAN = 15;
    localparam int POS_ISA_FAMILY_LO = 13;
    localparam int POS_ISA_REV_LO = 10;
    localparam int POS_MMU_KIND_LO = 7;
    localparam int POS_POLICY_LO = 0;

    // Fixed field values
    localparam logic [0:0] VAL_SECOND_WORD = 1'h1;
    localparam logic [5:0] VAL_UNIMPL_30_25 = 6'h00;
    localparam logic [0:0] VAL_SCRATCH_I = 1'h0;
    localparam logic [0:0] VAL_SCRATCH_D = 1'h0;
    localparam logic [0:0] VAL_CUSTOM = 1'h0;
    localparam logic [0:0] VAL_SIMPLE_BE = 1'h1;
    localparam logic [0:0] VAL_MULDIV_KIND = 1'h0;
    localparam logic [0:0] VAL_UNIMPL_19 = 1'h0;
    localparam logic [1:0] VAL_MERGE_MODE = 2'h2;
    localparam logic [0:0] VAL_BURST_ORDER = 1'h0;
    localparam logic [0:0] VAL_ENDIAN = 1'h0;
    localparam logic [1:0] VAL_ISA_FAMILY = 2'h0;
    localparam logic [2:0] VAL_ISA_REVISION = 3'h1;
    localparam logic [2:0] VAL_MMU_KIND = 3'h1;
    localparam logic [3:0] VAL_UNIMPL_6_3 = 4'h0;

    // Cached window policy codes
    localparam logic [2:0] POLICY_WT_NOALLOC = 3'h0;
    localparam logic [2:0] POLICY_UNCACHED = 3'h2;
    localparam logic [2:0] POLICY_WB_ALLOC = 3'h3;
    localparam logic [2:0] POLICY_RESET = POLICY_UNCACHED;

    // Address window decode on the top three address bits, top two for the mapped high window
    localparam logic [2:0] SEG_CACHED = 3'h4;
    localparam logic [2:0] SEG_UNCACHED = 3'h5;
    localparam logic [1:0] SEG_MAPPED_HI = 2'h3;

    typedef struct packed {
        logic second_word_present;
        logic [5:0] unimpl_30_25;
        logic instr_scratchpad_present;
        logic data_scratchpad_present;
        logic custom_instr_present;
        logic simple_byte_enable_only;
        logic multiply_divide_kind;
        logic unimpl_19;
        logic [1:0] merge_mode;
        logic burst_order;
        logic endian_select;
        logic [1:0] isa_family_code;
        logic [2:0] isa_revision_level;
        logic [2:0] mmu_kind;
        logic [3:0] unimpl_6_3;
        logic [2:0] cached_window_policy;
    } feature_word_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] regnum;
        logic [2:0] sel;
        logic [31:0] wdata;
    } cp0_req_t;

    typedef enum logic [1:0] {
        WIN_OTHER,
        WIN_CACHED_UNMAPPED,
        WIN_UNCACHED_UNMAPPED,
        WIN_MAPPED_HIGH
    } window_t;

    typedef struct packed {
        window_t window;
        logic cacheable;
        logic write_back;
        logic write_allocate;
        logic be_ok;
        logic fault;
    } access_attr_t;

    // Unused policy codes fold onto uncached
    function automatic logic [2:0] policy_remap(input logic [2:0] code);
        logic [2:0] r;
        r = POLICY_UNCACHED;
        if (code == POLICY_WB_ALLOC || code == POLICY_WT_NOALLOC || code == POLICY_UNCACHED) begin
            r = code;
        end
        return r;
    endfunction

endpackage

// file: verilog/core_feature_word.sv
// Purpose: Core feature word on the coprocessor-0 register port.
// Assumes: One request per cycle, synchronous to mclk.
// Notes: Only the cached window policy is writable.
// Operation
// R01: Bit 31 always reads one to show a second configuration word, and writes leave it.
// R02: Bits 30..25, 19 and 6..3 are unimplemented and read zero.
// R03: Bit 24 reads zero, no instruction scratchpad.
// R04: Bit 23 reads zero, no data scratchpad.
// R05: Bit 22 reads zero, no custom instructions.
// R06: Bit 21 reads one and the bus only carries simple byte-enable patterns.
// R07: Bit 20 reads zero, the fast multiply/divide unit.
// R08: Bits 18..17 read binary 10, write merging allowed.
// R09: Bit 16 reads zero, bursts go in sequential order.
// R10: Bit 15 reads zero, little-endian.
// R11: Bits 14..13 read 00, the 32-bit architecture family.
// R12: Bits 12..10 read 001, architecture release 2.
// R13: Bits 9..7 read 001, a translation-buffer based MMU.
// R14: Bits 2..0 pick the cached window policy: 011 write-back allocate, 010 uncached, 000 write-through.
// R15: Written codes 100 to 111 are stored as 010, uncached.
// R16: Software enables the MMU and sets up translation before touching the mapped high window.
// R17: A write changes only the policy field, which resets to 010.
`timescale 1ns/1ps
`default_nettype none
module core_feature_word
    import core_cfg_pkg::*;
#(
    parameter int ADDR_W = 32
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Coprocessor-0 register port
    input wire cp0_req_t cp0_req,
    output logic [31:0] cp0_rdata,
    output logic cp0_rvalid,
    output logic cp0_hit,
    // Access attribute lookup
    input wire logic lookup_valid,
    input wire logic [ADDR_W-1:0] lookup_addr,
    input wire logic [3:0] lookup_byte_en,
    input wire logic mmu_enabled,
    output access_attr_t lookup_attr,
    output logic lookup_attr_valid,
    // Build options for the rest of the core
    output feature_word_t feature
);

    if (ADDR_W != 32) begin : g_addr_check
        $error("core_feature_word supports only a 32-bit address");
    end

    typedef struct packed {
        logic [2:0] policy;
        logic [31:0] rdata;
        logic rvalid;
        logic hit;
        access_attr_t attr;
        logic attr_valid;
    } state_t;

    localparam state_t STATE_RESET = '{
        policy: POLICY_RESET,
        rdata: 32'h0000_0000,
        rvalid: 1'b0,
        hit: 1'b0,
        attr: '0,
        attr_valid: 1'b0
    };

    state_t state_ff;
    state_t nxt_state;
    feature_word_t word;
    access_attr_t attr_now;
    logic sel_match;

    // Fixed fields are constants so no write path can reach them
    always_comb begin
        word.second_word_present = VAL_SECOND_WORD; // R01
        word.unimpl_30_25 = VAL_UNIMPL_30_25; // R02
        word.instr_scratchpad_present = VAL_SCRATCH_I; // R03
        word.data_scratchpad_present = VAL_SCRATCH_D; // R04
        word.custom_instr_present = VAL_CUSTOM; // R05
        word.simple_byte_enable_only = VAL_SIMPLE_BE; // R06
        word.multiply_divide_kind = VAL_MULDIV_KIND; // R07
        word.unimpl_19 = VAL_UNIMPL_19; // R02
        word.merge_mode = VAL_MERGE_MODE; // R08
        word.burst_order = VAL_BURST_ORDER; // R09
        word.endian_select = VAL_ENDIAN; // R10
        word.isa_family_code = VAL_ISA_FAMILY; // R11
        word.isa_revision_level = VAL_ISA_REVISION; // R12
        word.mmu_kind = VAL_MMU_KIND; // R13
        word.unimpl_6_3 = VAL_UNIMPL_6_3; // R02
        word.cached_window_policy = state_ff.policy; // R14
    end

    assign sel_match = (cp0_req.regnum == CP0_REG_FEATURE) && (cp0_req.sel == CP0_SEL_FEATURE);

    window_classify u_classify (
        .addr(lookup_addr),
        .byte_en(lookup_byte_en),
        .policy(state_ff.policy),
        .mmu_enabled(mmu_enabled),
        .attr(attr_now)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_state.rvalid = cp0_req.rd;
        nxt_state.hit = cp0_req.rd && sel_match;
        if (cp0_req.rd) begin
            // Read returns the word as it stood before any same-cycle write
            nxt_state.rdata = sel_match ? 32'(word) : 32'h0000_0000;
        end
        if (cp0_req.wr && sel_match) begin
            // Only the policy bits of the written data are looked at
            nxt_state.policy = policy_remap(cp0_req.wdata[POS_POLICY_LO +: 3]); // R15 R17
        end
        nxt_state.attr_valid = lookup_valid;
        if (lookup_valid) begin
            nxt_state.attr = attr_now; // R16
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= STATE_RESET; // R17
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign cp0_rdata = state_ff.rdata;
    assign cp0_rvalid = state_ff.rvalid;
    assign cp0_hit = state_ff.hit;
    assign lookup_attr = state_ff.attr;
    assign lookup_attr_valid = state_ff.attr_valid;
    assign feature = word;

endmodule
`default_nettype wire

// file: verilog/window_classify.sv
// Purpose: Classifies an access by address window and gives its attributes.
// Assumes: Policy input is already remapped to a used code.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module window_classify
    import core_cfg_pkg::*;
(
    // Access
    input wire logic [31:0] addr,
    input wire logic [3:0] byte_en,
    // Configuration
    input wire logic [2:0] policy,
    input wire logic mmu_enabled,
    // Result
    output access_attr_t attr
);

    function automatic logic be_simple(input logic [3:0] be);
        logic ok;
        ok = 1'b0;
        unique case (be)
            4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    always_comb begin
        attr = '0;
        attr.be_ok = be_simple(byte_en); // R06
        if (addr[31:29] == SEG_CACHED) begin
            attr.window = WIN_CACHED_UNMAPPED;
            attr.cacheable = (policy != POLICY_UNCACHED); // R14
            attr.write_back = (policy == POLICY_WB_ALLOC); // R14
            attr.write_allocate = (policy == POLICY_WB_ALLOC); // R14
        end else if (addr[31:29] == SEG_UNCACHED) begin
            attr.window = WIN_UNCACHED_UNMAPPED;
        end else if (addr[31:30] == SEG_MAPPED_HI) begin
            // This block marks the mapped high window cacheable and faults it while the MMU is disabled
            attr.window = WIN_MAPPED_HIGH;
            attr.cacheable = 1'b1;
            attr.fault = ~mmu_enabled; // R16
        end else begin
            attr.window = WIN_OTHER;
        end
        if (!attr.be_ok) begin
            attr.fault = 1'b1; // R06
        end
    end

endmodule
`default_nettype wire
